// File: spc_speed_profile.sv
`timescale 1ns/1ps
module spc_speed_profile
  import spc_pkg::*;
(
  input  wire logic        mclk,    // System clock, 100 MHz
  input  wire logic        reset,   // Synchronous reset, active high
  input  wire logic [3:0]  addr,    // Register index
  input  wire logic [31:0] wdata,   // Write data
  input  wire logic        wr,      // Write strobe
  input  wire logic        rd,      // Read strobe
  output logic      [31:0] rdata,   // Read data, cycle after rd
  output logic             pulse,   // Motor step pulse
  output logic             busy     // Move in progress
);
  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [23:0] positioning_amount;
  logic [15:0] start_speed;
  logic [15:0] peak_speed;
  logic [15:0] accel_rate;
  logic [15:0] decel_rate;
  logic [10:0] speed_multiplier;
  logic [15:0] s_accel_range;
  logic [15:0] s_decel_range;
  logic [13:0] mode;
  spc_state_t  state;
  logic [15:0] cur;         // Present output speed
  logic [15:0] goal;        // Speed the ramp heads for
  logic        pend;        // Higher S-curve peak waiting
  logic [15:0] pend_val;
  logic [23:0] remain;
  logic [23:0] up_pulses;
  logic        rampdown;
  logic [15:0] trial_res;
  logic [3:0]  bitn;
  logic [7:0]  tick_cnt;
  logic        tick;
  logic [17:0] step_cnt;
  logic        step;

  wire logic        s_mode   = mode[MODE_CURVE_BIT];
  wire logic        corr_off = mode[MODE_OFF_BIT];
  wire logic        wr_start = wr && addr == OFS_CMD && wdata[CMD_START_BIT];
  wire logic        wr_stop  = wr && addr == OFS_CMD && wdata[CMD_STOP_BIT];
  wire logic [15:0] target   = rampdown ? start_speed : goal;
  wire logic        going_up = cur < target;

  // ----------------------------------------------------------------
  // Decoding used in several places
  // ----------------------------------------------------------------
  // Large S-range values saturate, as the ramp cannot use more
  function automatic logic [15:0] clip_s(input logic [15:0] v);
    clip_s = (v > S_RANGE_MAX) ? S_RANGE_MAX : v;
  endfunction : clip_s

  // Pulses needed (scaled) for a full ramp up and down to peak t
  function automatic logic [63:0] ramp_need(input logic [15:0] t);
    logic [63:0] sum;
    logic [63:0] rs;
    sum = 64'({16'd0, accel_rate}) + 64'({16'd0, decel_rate}) + 64'd2;
    rs  = 64'({16'd0, clip_s(s_accel_range)});
    if (!s_mode)
      ramp_need = (64'(t) * 64'(t) - 64'(start_speed) * 64'(start_speed)) * sum;
    else if (rs == 64'd0)
      ramp_need = (64'(t) * 64'(t) - 64'(start_speed) * 64'(start_speed)) * sum * 64'd2;
    else
      ramp_need = 64'({48'd0, t} + {48'd0, start_speed})
                * (64'({48'd0, t}) - 64'({48'd0, start_speed}) + rs * 64'd2) * sum;
  endfunction : ramp_need

  wire logic [63:0] avail = 64'(positioning_amount) * 64'({53'd0, speed_multiplier} + 64'd1)
                          * 64'(K_AREA);
  wire logic [15:0] cand  = trial_res | (16'd1 << bitn);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Each value lands whole in one write, so the ramp never sees half a word
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      positioning_amount <= RST_WORD24;
      start_speed        <= RST_WORD16;
      peak_speed         <= RST_WORD16;
      accel_rate         <= RST_WORD16;
      decel_rate         <= RST_WORD16;
      speed_multiplier   <= 11'd0;
      s_accel_range      <= RST_WORD16;
      s_decel_range      <= RST_WORD16;
      mode               <= 14'd0;
    end
    else if (wr)
    begin
      unique case (addr)
        OFS_AMOUNT: positioning_amount <= wdata[23:0];
        OFS_START:  start_speed        <= wdata[15:0];
        OFS_PEAK:   peak_speed         <= wdata[15:0];
        OFS_ACCEL:  accel_rate         <= wdata[15:0];
        OFS_DECEL:  decel_rate         <= wdata[15:0];
        OFS_MULT:   speed_multiplier   <= wdata[10:0];
        OFS_SACC:   s_accel_range      <= wdata[15:0];
        OFS_SDEC:   s_decel_range      <= wdata[15:0];
        OFS_MODE:   mode               <= wdata[13:0];
        default:    ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
      rdata <= 32'h00000000;
    else if (rd)
    begin
      unique case (addr)
        OFS_AMOUNT: rdata <= {8'h00, positioning_amount};
        OFS_START:  rdata <= {16'h0000, start_speed};
        OFS_PEAK:   rdata <= {16'h0000, peak_speed};
        OFS_ACCEL:  rdata <= {16'h0000, accel_rate};
        OFS_DECEL:  rdata <= {16'h0000, decel_rate};
        OFS_MULT:   rdata <= {21'h000000, speed_multiplier};
        OFS_SACC:   rdata <= {16'h0000, s_accel_range};
        OFS_SDEC:   rdata <= {16'h0000, s_decel_range};
        OFS_MODE:   rdata <= {18'h00000, mode};
        OFS_SPEED:  rdata <= {goal, cur};
        OFS_STAT:   rdata <= {rampdown, pend, state, 4'h0, remain};
        default:    rdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Time base and rate counter
  // ----------------------------------------------------------------
  // One tick per 200 ns; a speed step every rate+1 ticks, doubled inside
  // the S-curve bands, or at every step when the band is zero, so a band takes twice the linear time.
  always_ff @(posedge mclk)
  begin
    if (reset || tick_cnt == 8'(TICK_CYC - 1))
      tick_cnt <= 8'd0;
    else
      tick_cnt <= tick_cnt + 8'd1;
  end

  assign tick = tick_cnt == 8'(TICK_CYC - 1);

  logic [15:0] band;
  logic [17:0] interval;
  always_comb
  begin
    band     = clip_s(going_up ? s_accel_range : s_decel_range);
    interval = {2'b00, going_up ? accel_rate : decel_rate} + 18'd1;
    if (s_mode && (band == 16'd0 || cur < start_speed + band
                   || cur + band > goal))
      interval = interval << 1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset || state != SPC_RUN || cur == target)
    begin
      step_cnt <= 18'd0;
      step     <= 1'b0;
    end
    else if (tick && step_cnt + 18'd1 >= interval)
    begin
      step_cnt <= 18'd0;
      step     <= 1'b1;
    end
    else
    begin
      step_cnt <= tick ? step_cnt + 18'd1 : step_cnt;
      step     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Move sequencing, peak correction and speed ramp
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset || wr_stop)
    begin
      state     <= SPC_IDLE;
      cur       <= RST_WORD16;
      goal      <= RST_WORD16;
      pend      <= 1'b0;
      pend_val  <= RST_WORD16;
      trial_res <= RST_WORD16;
      bitn      <= 4'd0;
    end
    else
    begin
      unique case (state)
        SPC_IDLE:
          if (wr_start)
          begin
            cur       <= start_speed;
            goal      <= peak_speed;
            pend      <= 1'b0;
            trial_res <= RST_WORD16;
            bitn      <= 4'd15;
            state     <= corr_off ? SPC_RUN : SPC_CORRECT;
          end
        SPC_CORRECT:
        begin
          // Bit-serial search for the highest peak that still fits
          if (cand <= peak_speed && (cand <= start_speed || ramp_need(cand) < avail))
            trial_res <= cand;
          if (bitn == 4'd0)
          begin
            goal  <= (cand <= peak_speed && (cand <= start_speed
                      || ramp_need(cand) < avail)) ? cand : trial_res;
            state <= SPC_RUN;
          end
          bitn <= bitn - 4'd1;
        end
        SPC_RUN:
        begin
          if (remain == 24'd0)
            state <= SPC_IDLE;
          // Peak override: a higher S-curve peak waits for the old target
          if (wr && addr == OFS_PEAK)
          begin
            if (s_mode && cur < goal && wdata[15:0] > goal)
            begin
              pend     <= 1'b1;
              pend_val <= wdata[15:0];
            end
            else
            begin
              goal <= wdata[15:0];
              pend <= 1'b0;
            end
          end
          else if (pend && cur == goal)
          begin
            goal <= pend_val;
            pend <= 1'b0;
          end
          if (step)
          begin
            if (cur < start_speed)
              cur <= start_speed;
            else if (going_up)
              cur <= cur + 16'd1;
            else
              cur <= cur - 16'd1;
          end
        end
        default:
          state <= SPC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pulse bookkeeping and ramp-down
  // ----------------------------------------------------------------
  // Ramp-down starts once the pulses left match those spent climbing;
  // this mirrors the climb and assumes equal up and down rates.
  always_ff @(posedge mclk)
  begin
    if (reset || wr_stop || (state == SPC_IDLE && wr_start))
    begin
      remain    <= (state == SPC_IDLE && wr_start && !reset) ? positioning_amount
                                                           : RST_WORD24;
      up_pulses <= RST_WORD24;
      rampdown  <= 1'b0;
    end
    else if (state == SPC_RUN && pulse && remain != 24'd0)
    begin
      remain <= remain - 24'd1;
      if (!rampdown && cur < goal)
        up_pulses <= up_pulses + 24'd1;
      if (remain - 24'd1 <= up_pulses)
        rampdown <= 1'b1;
    end
  end

  spc_pulse_gen u_pulse
  (
    .mclk       (mclk),
    .reset      (reset),
    .enable     (state == SPC_RUN && remain != 24'd0 && !wr_stop),
    .speed      (cur),
    .multiplier (speed_multiplier),
    .pulse      (pulse)
  );

  assign busy = state != SPC_IDLE;
endmodule : spc_speed_profile

// File: spc_pkg.sv
package spc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ     = 100;
  localparam int          TICK_NS     = 200;  // Eight periods of the 40 MHz reference
  localparam int          TICK_CYC    = (TICK_NS * CLK_MHZ) / 1000;
  localparam logic [39:0] CLK_HZ      = 40'd100000000;
  localparam logic [7:0]  RATE_PPS    = 8'd200;  // 40,000,000 / 200,000
  localparam logic [15:0] K_AREA      = 16'd50000;
  localparam logic [15:0] S_RANGE_MAX = 16'hC350;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_AMOUNT = 4'h0;
  localparam logic [3:0] OFS_START  = 4'h1;
  localparam logic [3:0] OFS_PEAK   = 4'h2;
  localparam logic [3:0] OFS_ACCEL  = 4'h3;
  localparam logic [3:0] OFS_DECEL  = 4'h4;
  localparam logic [3:0] OFS_MULT   = 4'h5;
  localparam logic [3:0] OFS_SACC   = 4'h6;
  localparam logic [3:0] OFS_SDEC   = 4'h7;
  localparam logic [3:0] OFS_MODE   = 4'h8;
  localparam logic [3:0] OFS_CMD    = 4'h9;
  localparam logic [3:0] OFS_SPEED  = 4'hA;
  localparam logic [3:0] OFS_STAT   = 4'hB;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          MODE_RDM_BIT   = 8;   // rampdown_manual_select
  localparam int          MODE_CURVE_BIT = 9;   // curve_shape_select
  localparam int          MODE_OFF_BIT   = 10;  // peak_autocorrect_off
  localparam int          MODE_IDLE_LSB  = 11;  // idle_pulse_setting, 3 bits
  localparam int          CMD_START_BIT  = 0;
  localparam int          CMD_STOP_BIT   = 1;
  localparam logic [15:0] RST_WORD16     = 16'h0000;
  localparam logic [23:0] RST_WORD24     = 24'h000000;

  typedef enum logic [1:0]
  {
    SPC_IDLE    = 2'b00,
    SPC_CORRECT = 2'b01,
    SPC_RUN     = 2'b10
  } spc_state_t;
endpackage : spc_pkg

// File: spc_pulse_gen.sv
`timescale 1ns/1ps
module spc_pulse_gen
  import spc_pkg::*;
(
  input  wire logic        mclk,       // System clock
  input  wire logic        reset,      // Synchronous reset
  input  wire logic        enable,     // Pulses allowed
  input  wire logic [15:0] speed,      // Speed register units
  input  wire logic [10:0] multiplier, // speed_multiplier
  output logic             pulse       // One-cycle output pulse
);
  logic [39:0] acc;
  logic [39:0] limit;
  logic [39:0] next_acc;

  // ----------------------------------------------------------------
  // Phase accumulator
  // ----------------------------------------------------------------
  // Adds speed*200 per cycle against (mult+1)*clock rate, so the pulse
  // rate is speed*200/(mult+1) with no drift from rounding.
  always_comb
  begin
    limit    = 40'(({29'd0, multiplier} + 40'd1) * CLK_HZ);
    next_acc = acc + 40'({24'd0, speed} * {32'd0, RATE_PPS});
  end

  always_ff @(posedge mclk)
  begin
    if (reset || !enable)
    begin
      acc   <= 40'd0;
      pulse <= 1'b0;
    end
    else if (next_acc >= limit)
    begin
      acc   <= next_acc - limit;
      pulse <= 1'b1;
    end
    else
    begin
      acc   <= next_acc;
      pulse <= 1'b0;
    end
  end
endmodule : spc_pulse_gen

// File: spc_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the speed profile block
// ----------------------------------------------------------------
module spc_checker
  import spc_pkg::*;
(
  input  wire logic        mclk,   // System clock
  input  wire logic        reset,  // Synchronous reset
  input  wire logic [3:0]  addr,   // Register index
  input  wire logic [31:0] wdata,  // Write data
  input  wire logic        wr,     // Write strobe
  input  wire logic        rd,     // Read strobe
  input  wire logic [31:0] rdata,  // Read data
  input  wire logic        pulse,  // Step pulse
  input  wire logic        busy    // Move in progress
);
  logic corr_on;  // Copy of the autocorrect enable
  wire  go = wr && addr == OFS_CMD && wdata[CMD_START_BIT] && !wdata[CMD_STOP_BIT];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Shadow of the mode bit; without it the correction phase is invisible
  always_ff @(posedge mclk)
    if (reset)
      corr_on <= 1'b1;
    else if (wr && addr == OFS_MODE)
      corr_on <= !wdata[MODE_OFF_BIT];

  a_reset_clear: assert property (disable iff (1'b0) reset |=> !busy && !pulse && rdata == 32'h0)
    else $error("outputs not clear after reset");
  a_start_busy: assert property (go && !busy |=> busy)
    else $error("start did not raise busy");
  a_corr_quiet: assert property (go && !busy && corr_on |=> (busy && !pulse)[*8])
    else $error("pulse during peak correction");
  a_busy_cause: assert property ($rose(busy) |-> $past(go))
    else $error("busy rose without start");
  a_stop_abort: assert property (wr && addr == OFS_CMD && wdata[CMD_STOP_BIT] |=> !busy)
    else $error("stop did not end move");
  a_idle_quiet: assert property (!busy && !$past(busy) |-> !pulse)
    else $error("pulse while idle");
  a_pulse_short: assert property (pulse |=> !pulse[*2])
    else $error("pulse too wide or too close");
  a_read_hole: assert property (rd && addr > OFS_STAT |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without read");
endmodule : spc_checker

// File: spc_motor_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Motor driver at the pulse output
// ----------------------------------------------------------------
module spc_motor_model
(
  input  wire logic mclk,   // System clock
  input  wire logic reset,  // Synchronous reset
  input  wire logic pulse,  // Step input
  output int        steps,  // Steps taken
  output int        gap     // Cycles between last two steps
);
  int since;  // Cycles since last step

  // Counts steps and their spacing; a real driver only sees edges
  always @(posedge mclk)
    if (reset)
    begin
      steps <= 0;
      since <= 0;
      gap   <= 0;
    end
    else if (pulse)
    begin
      steps <= steps + 1;
      gap   <= since + 1;
      since <= 0;
    end
    else
      since <= since + 1;
endmodule : spc_motor_model

// File: test_spc_speed_profile.sv
`timescale 1ns/1ps
module test_spc_speed_profile
  import spc_pkg::*;
;
  logic        mclk  = 1'b0;   // Clock
  logic        reset = 1'b1;   // Reset
  logic [3:0]  addr  = 4'h0;   // Index
  logic [31:0] wdata = 32'h0;  // Write data
  logic        wr    = 1'b0;   // Write strobe
  logic        rd    = 1'b0;   // Read strobe
  logic [31:0] rdata;          // Read data
  logic        pulse;          // Step pulse
  logic        busy;           // Moving
  logic [31:0] d;              // Last read
  int          steps, gap, t0;
  int          cyc         = 0;
  int          err_count   = 0;
  int          checks_done = 0;

  spc_speed_profile dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pulse(pulse), .busy(busy));
  spc_motor_model u_motor (.mclk(mclk), .reset(reset), .pulse(pulse), .steps(steps),
    .gap(gap));

  // 100 MHz clock and a cycle count for timing checks
  initial
    forever #5 mclk = ~mclk;
  always @(posedge mclk)
    cyc <= cyc + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // One-cycle strobes; a fresh edge before each keeps drivers single
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge mclk);
    wr    <= 1'b0;
    @(negedge mclk);
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd   <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask : rd_reg

  // Common move set-up; accel and decel rates both zero
  task automatic setup(input logic [31:0] mode, input logic [31:0] amt,
                       input logic [31:0] lo_spd, input logic [31:0] hi_spd);
    wr_reg(OFS_MODE, mode);
    wr_reg(OFS_AMOUNT, amt);
    wr_reg(OFS_START, lo_spd);
    wr_reg(OFS_PEAK, hi_spd);
    wr_reg(OFS_ACCEL, 32'h0);
    wr_reg(OFS_DECEL, 32'h0);
    wr_reg(OFS_MULT, 32'h9);
  endtask : setup

  // Polls present speed; the time taken must sit in lo..hi cycles
  task automatic ramp_to(input logic [15:0] tgt, input int lo, input int hi);
    t0 = cyc;
    d  = 32'h0;
    while (d[15:0] !== tgt && cyc - t0 < hi + 20)
      rd_reg(OFS_SPEED);
    chk({31'h0, cyc - t0 >= lo && cyc - t0 <= hi}, 32'h1);
  endtask : ramp_to

  task automatic stop_move();
    wr_reg(OFS_CMD, 32'h2);
    chk({31'h0, busy}, 32'h0);
  endtask : stop_move

  // Field widths: upper bits read zero and no partial value shows
  task automatic t_regs();
    logic [3:0]  ix [5] = '{OFS_AMOUNT, OFS_START, OFS_PEAK, OFS_MULT, 4'hC};
    logic [31:0] mk [5] = '{32'h00FFFFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h000007FF, 32'h0};
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(ix[i], 32'hFFFFFFFF);
      rd_reg(ix[i]);
      chk(d, mk[i]);
    end
  endtask : t_regs

  // Constant speed: 50000 x 200 / 10 pps is one step per 100 cycles
  task automatic t_rate();
    int s0;
    setup(32'h400, 32'h3, 32'hC350, 32'hC350);
    s0 = steps;
    wr_reg(OFS_CMD, 32'h1);
    for (int i = 0; i < 1000 && busy === 1'b1; i++)
      @(negedge mclk);
    chk({31'h0, busy}, 32'h0);
    chk(steps - s0, 32'h3);
    chk({31'h0, gap >= 99 && gap <= 101}, 32'h1);
  endtask : t_rate

  // Linear ramps at 20 cycles a step (40 with accel rate 1), then overrides while running
  task automatic t_linear();
    setup(32'h400, 32'hFFFFFF, 32'h64, 32'h6E);
    wr_reg(OFS_CMD, 32'h1);
    ramp_to(16'h6E, 180, 206);
    wr_reg(OFS_PEAK, 32'h69);
    ramp_to(16'h69, 80, 106);
    wr_reg(OFS_ACCEL, 32'h1);
    wr_reg(OFS_PEAK, 32'h73);
    ramp_to(16'h73, 360, 406);
    wr_reg(OFS_PEAK, 32'hC8);
    repeat (200) @(posedge mclk);
    wr_reg(OFS_PEAK, 32'h70);
    ramp_to(16'h70, 0, 400);
    stop_move();
  endtask : t_linear

  // S-curve without bands: 40 cycles a step throughout
  task automatic t_scurve();
    setup(32'h600, 32'hFFFFFF, 32'h64, 32'h82);
    wr_reg(OFS_SACC, 32'h0);
    wr_reg(OFS_SDEC, 32'h0);
    wr_reg(OFS_CMD, 32'h1);
    repeat (200) @(posedge mclk);
    wr_reg(OFS_PEAK, 32'h8C);
    rd_reg(OFS_SPEED);
    chk(d[31:16], 32'h82);
    rd_reg(OFS_STAT);
    chk(d[30], 1'b1);
    ramp_to(16'h8C, 1300, 1450);
    wr_reg(OFS_PEAK, 32'h87);
    ramp_to(16'h87, 160, 206);
    wr_reg(OFS_PEAK, 32'h96);
    repeat (200) @(posedge mclk);
    wr_reg(OFS_PEAK, 32'h89);
    rd_reg(OFS_SPEED);
    chk(d[31:16], 32'h89);
    ramp_to(16'h89, 0, 600);
    stop_move();
  endtask : t_scurve

  // Amount 10 allows (p*p - 10000) * 2 < 5000000, so peak 1584; the pure
  // S-curve doubles the rate term (1122), a band of 10 needs (p+100)(p-80)
  task automatic t_correct();
    logic [31:0] md [4] = '{32'h0, 32'h400, 32'h200, 32'h200};
    logic [31:0] sa [4] = '{32'h0, 32'h0, 32'h0, 32'hA};
    logic [31:0] pk [4] = '{32'h630, 32'hBB8, 32'h462, 32'h625};
    logic [1:0]  st [4] = '{2'h1, 2'h2, 2'h1, 2'h1};
    for (int i = 0; i < 4; i++)
    begin
      setup(md[i], 32'hA, 32'h64, 32'hBB8);
      wr_reg(OFS_SACC, sa[i]);
      wr_reg(OFS_CMD, 32'h1);
      rd_reg(OFS_STAT);
      chk(d[29:28], st[i]);
      repeat (20) @(posedge mclk);
      rd_reg(OFS_SPEED);
      chk(d[31:16], pk[i]);
      stop_move();
    end
  endtask : t_correct

  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_rate();
    t_linear();
    t_scurve();
    t_correct();
    end_sim();
  end

  // Watchdog well beyond the expected run of about 4000 cycles
  initial
  begin
    repeat (60000) @(posedge mclk);
    err_count++;
    end_sim();
  end
endmodule : test_spc_speed_profile

bind spc_speed_profile spc_checker u_chk (.mclk(mclk), .reset(reset), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pulse(pulse), .busy(busy));
